// >>> logic/gut_totalizer.sv
// Gated up/down event totalizer with per-input debouncers and an APB register slave
//
// What this block does
// - Software selects totalize, time or frequency mode
// - Totalize mode ignores TTL, analog, trigger inputs
// - Up-count falling edge adds one
// - Down-count falling edge subtracts one
// - Rising or simultaneous up/down falls change nothing
// - Single count fall with direction high increments
// - Single count fall with direction low decrements
// - Single rise or direction change alone ignored
// - Edge gating: first gate rise enables counting
// - Edge gating: second gate rise disables counting
// - Edge gating ignores redundant rises and all falls
// - Level gating: count only while both gates high
// - Gating off: gates have no counting effect
// - Software trigger config written in totalize mode disables counting; others nothing
// - Software trigger command re-enables; otherwise nothing
// - Debounce waits minimum width before accepting change
// - Switch bank enables debounce per input
// - New level held 15 ms; 10 ms bounce rejected
`timescale 1ns/1ps
`include "gut_params.svh"

module gut_totalizer #(
  parameter int DEB_CYCLES = `GUT_DEB_CYCLES,
  parameter int CNT_W      = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  // APB slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  // Count and gate inputs, idle high
  input  wire logic             cnt_down_in,
  input  wire logic             cnt_up_in,
  input  wire logic             gate_first_in,
  input  wire logic             gate_second_in,
  input  wire logic             cnt_single_in,
  input  wire logic             up_dn_dir_in,
  // Switch positions 1..5, high means debounce on
  input  wire logic [4:0]       debounce_switch_bank_in,
  // Status
  output logic      [CNT_W-1:0] total_out,
  output logic                  count_en_out
);

  localparam int NIN   = 5;
  localparam int DCW   = $clog2(DEB_CYCLES + 1);
  localparam logic [DCW-1:0] DEB_LAST = DCW'(DEB_CYCLES - 1);

  // ---------------------------------------------------------------- input path
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  logic [NIN-1:0] clean;
  logic [NIN-1:0] clean_prev_reg;
  logic [NIN-1:0] fall;
  logic [NIN-1:0] rise;
  logic           dir_sync1_reg;
  logic           dir_sync2_reg;

  assign raw_in[gut_pkg::GUT_IN_DOWN]   = cnt_down_in;
  assign raw_in[gut_pkg::GUT_IN_UP]     = cnt_up_in;
  assign raw_in[gut_pkg::GUT_IN_GATE1]  = gate_first_in;
  assign raw_in[gut_pkg::GUT_IN_GATE2]  = gate_second_in;
  assign raw_in[gut_pkg::GUT_IN_SINGLE] = cnt_single_in;

  // Idle level is high so reset does not fake a falling edge
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Direction is not debounced, so it must settle before the count edge it qualifies
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dir_sync1_reg <= 1'b1;
      dir_sync2_reg <= 1'b1;
    end else begin
      dir_sync1_reg <= up_dn_dir_in;
      dir_sync2_reg <= dir_sync1_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_deb
      logic [DCW-1:0] cnt_reg;
      logic [DCW-1:0] cnt_next;
      logic           state_reg;
      logic           state_next;
      logic           differs;
      logic           expired;

      assign differs = sync2_reg[gi] != state_reg;
      assign expired = cnt_reg == DEB_LAST;

      // Any return to the accepted level restarts the wait, so with the switch on, bounces never reach the counter
      always_comb begin
        cnt_next   = '0;
        state_next = state_reg;
        if (!debounce_switch_bank_in[gi]) begin
          state_next = sync2_reg[gi];
        end else if (differs) begin
          if (expired) begin
            state_next = sync2_reg[gi];
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end

      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          cnt_reg   <= '0;
          state_reg <= 1'b1;
        end else begin
          cnt_reg   <= cnt_next;
          state_reg <= state_next;
        end
      end

      assign clean[gi] = state_reg;
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      clean_prev_reg <= '1;
    end else begin
      clean_prev_reg <= clean;
    end
  end

  // Edges come from accepted levels, so a rejected bounce never forms one
  assign fall = clean_prev_reg & ~clean;
  assign rise = ~clean_prev_reg & clean;

  // ---------------------------------------------------------------- registers
  gut_pkg::gut_mode_t mode_reg;
  gut_pkg::gut_gate_t gate_mode_reg;
  gut_pkg::gut_trig_t trig_cfg_reg;
  logic               sw_ok_reg;
  logic               edge_ok_reg;
  logic [CNT_W-1:0]   total_reg;
  logic [CNT_W-1:0]   total_next;
  logic               count_en_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  wire access_wait = psel_in & penable_in & ~pready_reg;
  wire access_done = psel_in & penable_in & pready_reg;
  wire wr_done     = access_done & pwrite_in;
  wire hit_ctrl    = paddr_in == `GUT_OFF_CTRL;
  wire hit_trig    = paddr_in == `GUT_OFF_TRIG_CFG;
  wire hit_sw      = paddr_in == `GUT_OFF_SW_TRIG;
  wire hit_total   = paddr_in == `GUT_OFF_TOTAL;
  wire hit_status  = paddr_in == `GUT_OFF_STATUS;
  wire hit_any     = hit_ctrl | hit_trig | hit_sw | hit_total | hit_status;
  wire wr_ctrl     = wr_done & hit_ctrl;
  wire wr_trig     = wr_done & hit_trig;
  wire wr_sw       = wr_done & hit_sw & pwdata_in[0];
  wire wr_total    = wr_done & hit_total;

  wire [1:0] wr_mode = pwdata_in[`GUT_CTRL_MODE_LSB +: 2];
  wire [1:0] wr_gate = pwdata_in[`GUT_CTRL_GATE_LSB +: 2];
  wire [1:0] wr_tcfg = pwdata_in[1:0];

  // Spare encodings are refused and the field keeps its value
  wire mode_valid = wr_mode != 2'(gut_pkg::GUT_MODE_SPARE);
  wire gate_valid = wr_gate != 2'(gut_pkg::GUT_GATE_SPARE);
  wire tcfg_valid = wr_tcfg != 2'(gut_pkg::GUT_TRIG_SPARE);
  wire sel_sw_cfg = wr_trig & (wr_tcfg == 2'(gut_pkg::GUT_TRIG_SW));

  // ---------------------------------------------------------------- gating
  wire is_total  = mode_reg == gut_pkg::GUT_MODE_TOTAL;
  wire lvl_ok    = clean[gut_pkg::GUT_IN_GATE1] & clean[gut_pkg::GUT_IN_GATE2];
  wire g1_rise   = rise[gut_pkg::GUT_IN_GATE1];
  wire g2_rise   = rise[gut_pkg::GUT_IN_GATE2];

  logic ext_ok;
  always_comb begin
    case (gate_mode_reg)
      gut_pkg::GUT_GATE_EDGE:  ext_ok = edge_ok_reg;
      gut_pkg::GUT_GATE_LEVEL: ext_ok = lvl_ok;
      default:                 ext_ok = 1'b1;
    endcase
  end

  // Counts pass only while the external gate and the software flag both allow them
  wire count_en = is_total & ext_ok & sw_ok_reg;

  // Start only while stopped, stop only while running; falls never act
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      edge_ok_reg <= 1'b0;
    end else if (!edge_ok_reg && g1_rise) begin
      edge_ok_reg <= 1'b1;
    end else if (edge_ok_reg && g2_rise) begin
      edge_ok_reg <= 1'b0;
    end
  end

  // Command wins over a same-cycle config write; both are idempotent
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sw_ok_reg <= `GUT_SW_OK_RST;
    end else if (wr_sw) begin
      sw_ok_reg <= 1'b1;
    end else if (sel_sw_cfg && is_total) begin
      sw_ok_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- counting
  wire       dir_up  = dir_sync2_reg;
  wire       c_fall  = fall[gut_pkg::GUT_IN_SINGLE];
  wire       up_ev   = fall[gut_pkg::GUT_IN_UP] | (c_fall & dir_up);
  wire       dn_ev   = fall[gut_pkg::GUT_IN_DOWN] | (c_fall & ~dir_up);
  wire [1:0] step    = {up_ev, dn_ev};

  // Rises never form events; an up and a down in one cycle cancel
  always_comb begin
    total_next = total_reg;
    if (wr_total) begin
      total_next = pwdata_in[CNT_W-1:0];
    end else if (count_en) begin
      case (step)
        2'b10:   total_next = total_reg + 1'b1;
        2'b01:   total_next = total_reg - 1'b1;
        default: total_next = total_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      total_reg <= `GUT_TOTAL_RST;
    end else begin
      total_reg <= total_next;
    end
  end

  // Registered so the output comes from a flip-flop; it lags the internal enable by one cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      count_en_reg <= 1'b0;
    end else begin
      count_en_reg <= count_en;
    end
  end

  // ---------------------------------------------------------------- APB
  // Reset mode is frequency, so nothing is totalized until software selects it
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      mode_reg <= gut_pkg::GUT_MODE_FREQ;
    end else if (wr_ctrl && mode_valid) begin
      mode_reg <= gut_pkg::gut_mode_t'(wr_mode);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      gate_mode_reg <= gut_pkg::GUT_GATE_OFF;
    end else if (wr_ctrl && gate_valid) begin
      gate_mode_reg <= gut_pkg::gut_gate_t'(wr_gate);
    end
  end

  // Trigger choice only matters to the software gate here; the other modes live outside this block
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      trig_cfg_reg <= gut_pkg::GUT_TRIG_NONE;
    end else if (wr_trig && tcfg_valid) begin
      trig_cfg_reg <= gut_pkg::gut_trig_t'(wr_tcfg);
    end
  end

  logic [31:0] status_word;
  logic [31:0] rdata;
  always_comb begin
    status_word = '0;
    status_word[`GUT_ST_COUNT_EN] = count_en;
    status_word[`GUT_ST_EXT_OK]   = ext_ok;
    status_word[`GUT_ST_SW_OK]    = sw_ok_reg;
    status_word[`GUT_ST_INPUT_LSB +: NIN] = clean;
    rdata = '0;
    if (hit_ctrl) begin
      rdata[`GUT_CTRL_MODE_LSB +: 2] = mode_reg;
      rdata[`GUT_CTRL_GATE_LSB +: 2] = gate_mode_reg;
    end else if (hit_trig) begin
      rdata[1:0] = trig_cfg_reg;
    end else if (hit_total) begin
      rdata[CNT_W-1:0] = total_reg;
    end else if (hit_status) begin
      rdata = status_word;
    end
  end

  // One wait cycle: pready rises in the second access cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= access_wait;
      pslverr_reg <= access_wait & ~hit_any;
    end
  end

  // Read data is captured in the wait cycle and holds until the next read
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      prdata_reg <= '0;
    end else if (access_wait && !pwrite_in) begin
      prdata_reg <= rdata;
    end
  end

  assign prdata_out   = prdata_reg;
  assign pready_out   = pready_reg;
  assign pslverr_out  = pslverr_reg;
  assign total_out    = total_reg;
  assign count_en_out = count_en_reg;

endmodule

// >>> shared/gut_params.svh
// Offsets, field positions, reset values and timing counts of the gated totalizer
`ifndef GUT_PARAMS_SVH
`define GUT_PARAMS_SVH

// Register byte offsets
`define GUT_OFF_CTRL      8'h00
`define GUT_OFF_TRIG_CFG  8'h04
`define GUT_OFF_SW_TRIG   8'h08
`define GUT_OFF_TOTAL     8'h0C
`define GUT_OFF_STATUS    8'h10

// Control register fields
`define GUT_CTRL_MODE_LSB 0
`define GUT_CTRL_GATE_LSB 2

// Status register fields
`define GUT_ST_COUNT_EN   0
`define GUT_ST_EXT_OK     1
`define GUT_ST_SW_OK      2
`define GUT_ST_INPUT_LSB  3

// Reset values
`define GUT_TOTAL_RST     32'h0000_0000
`define GUT_SW_OK_RST     1'b1

// Timing
`define GUT_CLK_HZ        10000000
`define GUT_DEB_HOLD_US   15000
`define GUT_BOUNCE_MAX_US 10000
`define GUT_DEB_CYCLES    ((`GUT_DEB_HOLD_US * (`GUT_CLK_HZ / 1000000)))

`endif

// >>> shared/gut_pkg.sv
// Types of the gated totalizer: measurement mode, gating mode, trigger configuration
package gut_pkg;

  typedef enum logic [1:0] {
    GUT_MODE_FREQ,
    GUT_MODE_TIME,
    GUT_MODE_TOTAL,
    GUT_MODE_SPARE
  } gut_mode_t;

  typedef enum logic [1:0] {
    GUT_GATE_OFF,
    GUT_GATE_EDGE,
    GUT_GATE_LEVEL,
    GUT_GATE_SPARE
  } gut_gate_t;

  typedef enum logic [1:0] {
    GUT_TRIG_NONE,
    GUT_TRIG_HW,
    GUT_TRIG_SW,
    GUT_TRIG_SPARE
  } gut_trig_t;

  // Debounced input order, matches the switch bank positions
  typedef enum logic [2:0] {
    GUT_IN_DOWN,
    GUT_IN_UP,
    GUT_IN_GATE1,
    GUT_IN_GATE2,
    GUT_IN_SINGLE
  } gut_input_t;

endpackage

// >>> test/gut_src.sv
// Behavioural contact or pulse source for count, gate and direction pins
`timescale 1ns/1ps
module gut_src (
  input  wire logic clk_in,
  output logic [5:0] pins_out
);
  // Bits: 0 down, 1 up, 2 gate1, 3 gate2, 4 single, 5 direction; idle high like an open input
  initial pins_out = 6'h3F;
  // Unmasked pins keep their level, direction never moves inside a pulse
  task automatic pulse(input logic [4:0] mask, input int lo, input int hi);
    @(posedge clk_in) pins_out[4:0] <= pins_out[4:0] & ~mask;
    repeat (lo) @(posedge clk_in);
    pins_out[4:0] <= pins_out[4:0] | mask;
    repeat (hi) @(posedge clk_in);
  endtask
  task automatic set(input int idx, input logic v);
    @(posedge clk_in) pins_out[idx] <= v;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// >>> test/gut_totalizer_asserts.sv
// Port checker of the gated totalizer, bound to the top module
`timescale 1ns/1ps
module gut_totalizer_asserts #(
  parameter int DEB_CYCLES = 20,
  parameter int CNT_W      = 32
) (
  input wire logic             clk_sys_in,
  input wire logic             nrst_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic             pwrite_in,
  input wire logic [7:0]       paddr_in,
  input wire logic [31:0]      pwdata_in,
  input wire logic [31:0]      prdata_out,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  input wire logic [CNT_W-1:0] total_out,
  input wire logic             count_en_out
);
  wire wr_total = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 8'h0C;
  wire unmapped = paddr_in > 8'h10 || paddr_in[1:0] != 2'h0;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_wait; psel_in && penable_in && !pready_out; endsequence
  chk_one_wait: assert property (s_setup ##1 s_wait |=> pready_out)
    else $error("access did not end after one wait state");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  chk_err_decode: assert property (pready_out |-> pslverr_out == unmapped)
    else $error("pslverr does not match the address decode");
  chk_unmapped_zero: assert property (pready_out && !pwrite_in && unmapped |-> prdata_out == 32'h0000_0000)
    else $error("unmapped read returned data");
  chk_step_one: assert property ($changed(total_out) && !$past(wr_total) |->
    total_out - $past(total_out) == 1 || $past(total_out) - total_out == 1)
    else $error("total moved by more than one");
  chk_total_load: assert property (wr_total |=> total_out == $past(pwdata_in))
    else $error("total write not loaded");
  chk_count_gated: assert property ($changed(total_out) && !$past(wr_total) |-> count_en_out)
    else $error("total changed while counting disabled");
  chk_reset_values: assert property ($rose(nrst_in) |-> total_out == 0 && !count_en_out && !pready_out)
    else $error("outputs not cleared by reset");
endmodule

bind gut_totalizer gut_totalizer_asserts #(.DEB_CYCLES(DEB_CYCLES), .CNT_W(CNT_W)) chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .total_out(total_out), .count_en_out(count_en_out));

// >>> test/testbench.sv
// Self-checking bench of the gated totalizer against an integer model
`timescale 1ns/1ps
module testbench;
  localparam int DEB = 20;
  logic        clk_sys_in, nrst_in, psel, penable, pwrite, pready, pslverr, count_en, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lf, total;
  logic [4:0]  deb_sw;
  logic [5:0]  pins;
  int          errors, checks_done, exp_total;
  gut_src src (.clk_in(clk_sys_in), .pins_out(pins));
  gut_totalizer #(.DEB_CYCLES(DEB), .CNT_W(32)) uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .cnt_down_in(pins[0]),
    .cnt_up_in(pins[1]), .gate_first_in(pins[2]), .gate_second_in(pins[3]), .cnt_single_in(pins[4]),
    .up_dn_dir_in(pins[5]), .debounce_switch_bank_in(deb_sw), .total_out(total), .count_en_out(count_en));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  // Waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in) begin
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
    end
    @(posedge clk_sys_in) penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Model: pair falls count unless both fall, single follows direction
  task automatic cnt(input logic [4:0] m, input int lo, input bit en);
    src.pulse(m, lo, lo + 6);
    if (en && m[1] != m[0]) exp_total += m[1] ? 1 : -1;
    if (en && m[4]) exp_total += pins[5] ? 1 : -1;
    chk("total_out", exp_total, total);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Whole run is near 730 cycles; 50000 means a hang
  initial begin
    #5_000_000;
    errors++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, deb_sw, nrst_in} = '0;
    errors = 0;
    checks_done = 0;
    exp_total = 0;
    lf = 32'hAAAC;
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    apb(0, 8'h10, 0);
    chk("status", 32'h0000_00FE, rd);
    apb(0, 8'h14, 0);
    chk("pslverr", 1, err);
    cnt(5'h02, 4, 0);
    apb(1, 8'h00, 1);
    cnt(5'h01, 4, 0);
    apb(1, 8'h00, 2);
    apb(1, 8'h00, 3);
    apb(0, 8'h00, 0);
    chk("ctrl", 2, rd);
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      src.set(5, lf[0]);
      cnt(i[1] ? (i[0] ? 5'h03 : 5'h10) : (i[0] ? 5'h01 : 5'h02), 4, 1);
    end
    $display("test counting done");
    lf = lfsr(lf);
    exp_total = lf;
    apb(1, 8'h0C, lf);
    apb(0, 8'h0C, 0);
    chk("total_rd", exp_total, rd);
    apb(1, 8'h04, 0);
    cnt(5'h01, 4, 1);
    apb(1, 8'h04, 1);
    cnt(5'h02, 4, 1);
    apb(1, 8'h04, 2);
    cnt(5'h02, 4, 0);
    chk("count_en", 0, count_en);
    apb(1, 8'h04, 2);
    apb(1, 8'h08, 1);
    cnt(5'h02, 4, 1);
    apb(1, 8'h08, 1);
    cnt(5'h01, 4, 1);
    $display("test software gate done");
    apb(1, 8'h00, 6);
    cnt(5'h08, 4, 0);
    cnt(5'h02, 4, 0);
    cnt(5'h04, 4, 0);
    cnt(5'h02, 4, 1);
    cnt(5'h04, 4, 0);
    cnt(5'h01, 4, 1);
    cnt(5'h08, 4, 0);
    cnt(5'h02, 4, 0);
    apb(1, 8'h00, 10);
    src.set(2, 0);
    cnt(5'h02, 4, 0);
    src.set(2, 1);
    cnt(5'h02, 4, 1);
    apb(1, 8'h00, 2);
    src.set(3, 0);
    cnt(5'h02, 4, 1);
    src.set(3, 1);
    $display("test gating done");
    @(posedge clk_sys_in) deb_sw <= 5'h02;
    cnt(5'h02, 10, 0);
    cnt(5'h02, 30, 1);
    cnt(5'h01, 4, 1);
    @(posedge clk_sys_in) nrst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("total_rst", 0, total);
    chk("count_en_rst", 0, count_en);
    $display("test debounce and reset done");
    conclude();
  end
endmodule
